// ---- verilog/rws_pkg.sv ----
package rws_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] A_WCODE = 12'h000;
    localparam logic [11:0] A_SENS  = 12'h004;
    localparam logic [11:0] A_FSG1  = 12'h008;
    localparam logic [11:0] A_TRT1  = 12'h00C;
    localparam logic [11:0] A_TRT2  = 12'h010;
    localparam logic [11:0] A_TRT3  = 12'h014;
    localparam logic [11:0] A_SRG4  = 12'h018;
    localparam logic [11:0] A_SRG5  = 12'h01C;
    localparam logic [11:0] A_IFG   = 12'h020;
    localparam logic [11:0] A_RTRIG = 12'h024;
    localparam logic [11:0] A_ISTAT = 12'h028;
    localparam logic [11:0] A_IMASK = 12'h02C;
    // ------------------------------------------------------------
    // reset values: thermal elements 0 and 1 left out
    // ------------------------------------------------------------
    localparam logic [8:0]  TRT12_RST = 9'h0FC;
    localparam logic [8:0]  TRT3_RST  = 9'h100;
    localparam logic [15:0] SRG_RST   = 16'hFCFC;
    // ------------------------------------------------------------
    // synchronised pin positions
    // ------------------------------------------------------------
    localparam int P_BATT = 0;
    localparam int P_TCS  = 1;
    localparam int P_PSU  = 2;
    localparam int P_COMM = 3;
    localparam int P_TH1  = 4;
    localparam int P_TH2  = 5;
    localparam int P_CAL  = 6;
    localparam int P_INTF = 7;
    localparam int P_DIN  = 8;
    localparam int PIN_W  = 13;
    // ------------------------------------------------------------
    // warning code bit positions (weight = 2**position); FSG_TCS_OUT2 is a function group one bit
    // ------------------------------------------------------------
    localparam int W_BATT = 0;
    localparam int W_TCS  = 1;
    localparam int W_PSU  = 2;
    localparam int W_COMM = 3;
    localparam int W_MOD  = 4;
    localparam int W_RNG  = 5;
    localparam int W_CH   = 6;
    localparam int W_TH1  = 12;
    localparam int W_TH2  = 13;
    localparam int FSG_TCS_OUT2 = 7;
    // ------------------------------------------------------------
    // limits in tenths of a percent of range, timing
    // ------------------------------------------------------------
    localparam logic signed [11:0] REF_TOL  = 12'sh00F;
    localparam logic signed [11:0] RANGE_LO = -12'sh028;
    localparam logic signed [11:0] RANGE_HI = 12'sh410;
    localparam int FILT_TIME_S = 8;
    localparam int BLINK_MS    = 250;
    localparam int CLK_HZ      = 25_000_000;
endpackage

// ---- verilog/rws_supervisor.sv ----
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - warnings alone keep protection running; ready lamp stays steadily on
// - concurrent warnings form one code, the sum of active weights
// - weights: battery 1, tcs 2, psu heat 4, comm 8, module 16, range 32
// - open or short on sensor channels 1..6 gives weights 64..2048
// - open or short on thermistor one gives 4096, thermistor two 8192
// - warning code cannot be cleared by hand; it goes with the fault
// - switch 8 of function group one adds tcs warning to signal out two
// - sample discarded when reference offset deviates over 1.5 percent
// - reference fault lasting the eight second filter disables all inputs
// - inputs come back once the reference fault is gone
// - failed self-calibration disables all inputs until it succeeds
// - one input disabled outside -4..104 percent or on open/short
// - per-input function groups; separate recorder trigger enable
// - trip routing groups; default non-thermal to outs 1,2, restart to 3
// - routing groups four/five pick pickup and alarm for signal outs
// - fault contact energized normally, released on internal fault
// - internal fault: lamp flashes, power and signal outputs reset and locked
module rws_supervisor #(
    parameter int FILT_CYC  = rws_pkg::FILT_TIME_S * rws_pkg::CLK_HZ,
    parameter int BLINK_CYC = rws_pkg::BLINK_MS * (rws_pkg::CLK_HZ / 1000),
    parameter int NCH       = 6
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic [12:0]        faultPins,
    input  wire logic               sampleStrobe,
    input  wire logic [2:0]         sampleChan,
    input  wire logic signed [11:0] sampleValue,
    input  wire logic               sampleOpenShort,
    input  wire logic signed [11:0] refOffset,
    input  wire logic [8:0]         tripIn,
    input  wire logic [7:0]         pickupIn,
    input  wire logic [7:0]         alarmIn,
    output logic                    filtValid,
    output logic [2:0]              filtChan,
    output logic signed [11:0]      filtValue,
    output logic [5:0]              sensorEnable,
    output logic [13:0]             warningCode,
    output logic [2:0]              powerOutputs,
    output logic                    signalOutputOne,
    output logic                    signalOutputTwo,
    output logic                    internalFault,
    output logic                    readyLed,
    output logic                    blockOut,
    output logic                    unlatchOut,
    output logic                    remoteOut,
    output logic                    recorderTrigger,
    output logic                    irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [12:0]        sync1;
        logic [12:0]        sync2;
        logic [4:0]         dinPrev;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
        logic [7:0]         fsg1;
        logic [8:0]         trt1;
        logic [8:0]         trt2;
        logic [8:0]         trt3;
        logic [15:0]        srg4;
        logic [15:0]        srg5;
        logic [14:0]        ifg;
        logic [4:0]         rtrig;
        logic [2:0]         istat;
        logic [2:0]         imask;
        logic               refFault;
        logic               refOff;
        logic [31:0]        refTimer;
        logic [5:0]         chOff;
        logic [5:0]         chOpen;
        logic [5:0]         chRange;
        logic               fValid;
        logic [2:0]         fChan;
        logic signed [11:0] fValue;
        logic [5:0]         sensEn;
        logic [13:0]        wcode;
        logic [2:0]         po;
        logic               sigOne;
        logic               sigTwo;
        logic               faultRelay;
        logic               ledOn;
        logic [31:0]        blinkCnt;
        logic               blk;
        logic               unl;
        logic               rem;
        logic               rec;
        logic               irq;
    } rws_state_s;

    rws_state_s st;
    rws_state_s next_st;

    function automatic logic inLimits(input logic signed [11:0] v,
                                      input logic signed [11:0] lo,
                                      input logic signed [11:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [13:0] codeNow;
    logic        intfNow;
    logic        modFault;
    logic        acc;
    logic        bad;
    logic [2:0]  ev;
    logic [4:0]  din;
    logic [31:0] rd;
    logic        hit;

    always_comb begin
        next_st = st;
        next_st.sync1 = faultPins;
        next_st.sync2 = st.sync1;
        din = st.sync2[rws_pkg::P_DIN +: 5];
        next_st.dinPrev = din;
        intfNow = st.sync2[rws_pkg::P_INTF];

        // reference check right after each sample
        acc = 1'b0;
        bad = 1'b0;
        if (sampleStrobe) begin
            if (!inLimits(refOffset, -rws_pkg::REF_TOL, rws_pkg::REF_TOL)) begin
                next_st.refFault = 1'b1;
            end else begin
                next_st.refFault = 1'b0;
                next_st.refOff = 1'b0;
                next_st.refTimer = '0;
                acc = (sampleChan < 3'(NCH));
            end
        end
        if (st.refFault && !st.refOff) begin
            if (st.refTimer == 32'(FILT_CYC - 1)) begin
                next_st.refOff = 1'b1;
            end else begin
                next_st.refTimer = st.refTimer + 32'h0000_0001;
            end
        end

        // per channel validation
        next_st.fValid = 1'b0;
        if (acc) begin
            bad = sampleOpenShort || !inLimits(sampleValue,
                rws_pkg::RANGE_LO, rws_pkg::RANGE_HI);
            next_st.chOff[sampleChan] = bad;
            next_st.chOpen[sampleChan] = sampleOpenShort;
            next_st.chRange[sampleChan] = !sampleOpenShort && bad;
            next_st.fValid = !bad && !st.refOff && !st.sync2[rws_pkg::P_CAL];
            next_st.fChan = sampleChan;
            next_st.fValue = sampleValue;
        end
        modFault = st.refOff || st.sync2[rws_pkg::P_CAL];
        next_st.sensEn = ~st.chOff & {6{!modFault}};

        // warning code rebuilt every cycle, no clear path
        codeNow = '0;
        codeNow[rws_pkg::W_BATT] = st.sync2[rws_pkg::P_BATT];
        codeNow[rws_pkg::W_TCS] = st.sync2[rws_pkg::P_TCS];
        codeNow[rws_pkg::W_PSU] = st.sync2[rws_pkg::P_PSU];
        codeNow[rws_pkg::W_COMM] = st.sync2[rws_pkg::P_COMM];
        codeNow[rws_pkg::W_MOD] = modFault;
        codeNow[rws_pkg::W_RNG] = |st.chRange;
        codeNow[rws_pkg::W_CH +: 6] = st.chOpen;
        codeNow[rws_pkg::W_TH1] = st.sync2[rws_pkg::P_TH1];
        codeNow[rws_pkg::W_TH2] = st.sync2[rws_pkg::P_TH2];
        next_st.wcode = codeNow;

        // output routing, reset and locked on internal fault
        if (intfNow) begin
            next_st.po = '0;
            next_st.sigOne = 1'b0;
            next_st.sigTwo = 1'b0;
            next_st.faultRelay = 1'b0;
            if (st.blinkCnt == 32'(BLINK_CYC - 1)) begin
                next_st.blinkCnt = '0;
                next_st.ledOn = !st.ledOn;
            end else begin
                next_st.blinkCnt = st.blinkCnt + 32'h0000_0001;
            end
        end else begin
            next_st.po[0] = |(tripIn & st.trt1);
            next_st.po[1] = |(tripIn & st.trt2);
            next_st.po[2] = |(tripIn & st.trt3);
            next_st.sigOne = |({alarmIn, pickupIn} & st.srg4);
            next_st.sigTwo = |({alarmIn, pickupIn} & st.srg5)
                || (st.sync2[rws_pkg::P_TCS]
                    && st.fsg1[rws_pkg::FSG_TCS_OUT2]);
            next_st.faultRelay = 1'b1;
            next_st.ledOn = 1'b1;
            next_st.blinkCnt = '0;
        end

        // digital input functions
        next_st.blk = 1'b0;
        next_st.unl = 1'b0;
        next_st.rem = 1'b0;
        for (int i = 0; i < 5; i++) begin
            next_st.blk = next_st.blk || (din[i] && st.ifg[3*i]);
            next_st.unl = next_st.unl || (din[i] && st.ifg[3*i+1]);
            next_st.rem = next_st.rem || (din[i] && st.ifg[3*i+2]);
        end
        next_st.rec = |(din & ~st.dinPrev & st.rtrig);

        // ------------------------------------------------------------
        // apb slave: one wait state, write lands at the pready edge
        // ------------------------------------------------------------
        rd = '0;
        hit = 1'b1;
        unique case (paddr)
            rws_pkg::A_WCODE: rd = {18'h0_0000, st.wcode};
            rws_pkg::A_SENS:  rd = {26'h000_0000, st.sensEn};
            rws_pkg::A_FSG1:  rd = {24'h00_0000, st.fsg1};
            rws_pkg::A_TRT1:  rd = {23'h00_0000, st.trt1};
            rws_pkg::A_TRT2:  rd = {23'h00_0000, st.trt2};
            rws_pkg::A_TRT3:  rd = {23'h00_0000, st.trt3};
            rws_pkg::A_SRG4:  rd = {16'h0000, st.srg4};
            rws_pkg::A_SRG5:  rd = {16'h0000, st.srg5};
            rws_pkg::A_IFG:   rd = {17'h0_0000, st.ifg};
            rws_pkg::A_RTRIG: rd = {27'h000_0000, st.rtrig};
            rws_pkg::A_ISTAT: rd = {29'h0000_0000, st.istat};
            rws_pkg::A_IMASK: rd = {29'h0000_0000, st.imask};
            default:          hit = 1'b0;
        endcase
        next_st.pready = 1'b0;
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = pwrite ? 32'h0000_0000 : rd;
            next_st.pslverr = !hit;
        end

        ev[0] = |(codeNow & ~st.wcode);
        ev[1] = modFault && (|st.sensEn);
        ev[2] = intfNow && st.faultRelay;
        next_st.istat = st.istat | ev;
        if (psel && penable && st.pready && pwrite) begin
            unique case (paddr)
                rws_pkg::A_FSG1:  next_st.fsg1 = pwdata[7:0];
                rws_pkg::A_TRT1:  next_st.trt1 = pwdata[8:0];
                rws_pkg::A_TRT2:  next_st.trt2 = pwdata[8:0];
                rws_pkg::A_TRT3:  next_st.trt3 = pwdata[8:0];
                rws_pkg::A_SRG4:  next_st.srg4 = pwdata[15:0];
                rws_pkg::A_SRG5:  next_st.srg5 = pwdata[15:0];
                rws_pkg::A_IFG:   next_st.ifg = pwdata[14:0];
                rws_pkg::A_RTRIG: next_st.rtrig = pwdata[4:0];
                rws_pkg::A_IMASK: next_st.imask = pwdata[2:0];
                // set wins over clear
                rws_pkg::A_ISTAT:
                    next_st.istat = (st.istat & ~pwdata[2:0]) | ev;
                default: ;
            endcase
        end
        next_st.irq = |(next_st.istat & next_st.imask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '0;
            st.trt1 <= rws_pkg::TRT12_RST;
            st.trt2 <= rws_pkg::TRT12_RST;
            st.trt3 <= rws_pkg::TRT3_RST;
            st.srg4 <= rws_pkg::SRG_RST;
            st.srg5 <= rws_pkg::SRG_RST;
            st.sensEn <= '1;
            st.faultRelay <= 1'b1;
            st.ledOn <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pready          = st.pready;
    assign prdata          = st.prdata;
    assign pslverr         = st.pslverr;
    assign filtValid       = st.fValid;
    assign filtChan        = st.fChan;
    assign filtValue       = st.fValue;
    assign sensorEnable    = st.sensEn;
    assign warningCode     = st.wcode;
    assign powerOutputs    = st.po;
    assign signalOutputOne = st.sigOne;
    assign signalOutputTwo = st.sigTwo;
    assign internalFault   = st.faultRelay;
    assign readyLed        = st.ledOn;
    assign blockOut        = st.blk;
    assign unlatchOut      = st.unl;
    assign remoteOut       = st.rem;
    assign recorderTrigger = st.rec;
    assign irq             = st.irq;

    logic fsg1Tcs;
    assign fsg1Tcs = st.fsg1[rws_pkg::FSG_TCS_OUT2];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_ready_steady: assert property (
        !st.sync2[rws_pkg::P_INTF] |=> readyLed)
        else $error("ready lamp not steady without internal fault");
    a_code_zero: assert property (
        st.sync2[5:0] == 6'h00 && !st.refOff && st.chOpen == '0
        && st.chRange == '0 && !st.sync2[rws_pkg::P_CAL]
        |=> warningCode == 14'h0000)
        else $error("warning code not zero with no fault");
    a_therm_weight: assert property (
        st.sync2[rws_pkg::P_TH1] |=> warningCode[rws_pkg::W_TH1])
        else $error("thermistor one weight missing");
    a_ref_discard: assert property (
        sampleStrobe && (refOffset > rws_pkg::REF_TOL
        || refOffset < -rws_pkg::REF_TOL) |=> !filtValid)
        else $error("sample kept despite reference deviation");
    a_ref_disable: assert property (
        st.refOff |=> sensorEnable == 6'h00)
        else $error("inputs still enabled after reference timeout");
    a_cal_disable: assert property (
        st.sync2[rws_pkg::P_CAL] |=> sensorEnable == 6'h00)
        else $error("inputs enabled during calibration failure");
    a_chan_off: assert property (
        sampleStrobe && !st.sync2[rws_pkg::P_CAL] && !st.refOff
        && refOffset == 12'sh000 && sampleChan == 3'h2 && sampleOpenShort
        |=> ##1 !sensorEnable[2])
        else $error("faulty channel not disabled");
    a_tcs_route: assert property (
        st.sync2[rws_pkg::P_TCS] && fsg1Tcs && !st.sync2[rws_pkg::P_INTF]
        |=> signalOutputTwo)
        else $error("tcs warning not on signal output two");
    a_fault_lock: assert property (
        st.sync2[rws_pkg::P_INTF] |=> powerOutputs == 3'h0
        && !signalOutputOne && !internalFault)
        else $error("outputs not locked on internal fault");
endmodule

// ---- bench/rws_sensor_model.sv ----
`timescale 1ns/1ps
module rws_sensor_model (
    input  wire logic               ref_clk,
    output logic                    sampleStrobe,
    output logic [2:0]              sampleChan,
    output logic signed [11:0]      sampleValue,
    output logic                    sampleOpenShort,
    output logic signed [11:0]      refOffset
);
    initial begin
        sampleStrobe    = 1'b0;
        sampleChan      = 3'h7;
        sampleValue     = 12'sh000;
        sampleOpenShort = 1'b0;
        refOffset       = 12'sh000;
    end

    // one reading, the reference measured right after it
    task automatic sample(input logic [2:0] ch, input logic signed [11:0] v,
                          input logic os, input logic signed [11:0] r);
        @(posedge ref_clk);
        sampleStrobe    <= 1'b1;
        sampleChan      <= ch;
        sampleValue     <= v;
        sampleOpenShort <= os;
        refOffset       <= r;
        @(posedge ref_clk);
        // released lines do not keep the old value
        sampleStrobe    <= 1'b0;
        sampleChan      <= ~ch;
        sampleValue     <= ~v;
        sampleOpenShort <= ~os;
        refOffset       <= ~r;
    endtask
endmodule

// ---- bench/rws_supervisor_bench.sv ----
`timescale 1ns/1ps
module rws_supervisor_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               ref_clk, resetn, psel, penable, pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               pready, pslverr, err, seen;
    logic [12:0]        faultPins;
    logic               sampleStrobe, sampleOpenShort, filtValid;
    logic [2:0]         sampleChan, filtChan, powerOutputs;
    logic signed [11:0] sampleValue, refOffset, filtValue;
    logic [8:0]         tripIn;
    logic [7:0]         pickupIn, alarmIn;
    logic [5:0]         sensorEnable;
    logic [13:0]        warningCode;
    logic               signalOutputOne, signalOutputTwo, internalFault;
    logic               readyLed, blockOut, unlatchOut, remoteOut;
    logic               recorderTrigger, irq;
    int                 n_mismatch, checked;
    int                 wt[6] = '{1, 2, 4, 8, 4096, 8192};

    rws_supervisor #(.FILT_CYC(50), .BLINK_CYC(4), .NCH(6)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .faultPins(faultPins),
        .sampleStrobe(sampleStrobe), .sampleChan(sampleChan),
        .sampleValue(sampleValue), .sampleOpenShort(sampleOpenShort),
        .refOffset(refOffset), .tripIn(tripIn), .pickupIn(pickupIn),
        .alarmIn(alarmIn), .filtValid(filtValid), .filtChan(filtChan),
        .filtValue(filtValue), .sensorEnable(sensorEnable),
        .warningCode(warningCode), .powerOutputs(powerOutputs),
        .signalOutputOne(signalOutputOne),
        .signalOutputTwo(signalOutputTwo),
        .internalFault(internalFault), .readyLed(readyLed),
        .blockOut(blockOut), .unlatchOut(unlatchOut),
        .remoteOut(remoteOut), .recorderTrigger(recorderTrigger),
        .irq(irq));

    rws_sensor_model PTR (
        .ref_clk(ref_clk), .sampleStrobe(sampleStrobe),
        .sampleChan(sampleChan), .sampleValue(sampleValue),
        .sampleOpenShort(sampleOpenShort), .refOffset(refOffset));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            test_done();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pins(input logic [12:0] v);
        @(posedge ref_clk);
        faultPins <= v;
        cyc(4);
    endtask

    // outputs as {power three..one, signal one, signal two}
    task automatic elem(input logic [8:0] t, input logic [7:0] p,
                        input logic [7:0] a, input logic [4:0] e);
        @(posedge ref_clk);
        tripIn   <= t;
        pickupIn <= p;
        alarmIn  <= a;
        cyc(2);
        chk("outputs", 32'(e),
            32'({powerOutputs, signalOutputOne, signalOutputTwo}));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("internalFault", 32'h0000_0001, 32'(internalFault));
        chk("readyLed", 32'h0000_0001, 32'(readyLed));
        chk("sensorEnable", 32'h0000_003F, 32'(sensorEnable));
        chk("warningCode", 32'h0000_0000, 32'(warningCode));
        apb(1'b0, rws_pkg::A_TRT1, 32'h0000_0000);
        chk("trt1", 32'(rws_pkg::TRT12_RST), rd);
        apb(1'b0, rws_pkg::A_TRT3, 32'h0000_0000);
        chk("trt3", 32'(rws_pkg::TRT3_RST), rd);
        apb(1'b0, rws_pkg::A_SRG5, 32'h0000_0000);
        chk("srg5", 32'(rws_pkg::SRG_RST), rd);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(err));
    endtask

    task automatic t_warn();
        for (int i = 0; i < 6; i++) begin
            pins(13'(1 << i));
            chk("warningCode", 32'(wt[i]), 32'(warningCode));
        end
        pins(13'h003F);
        chk("warningCode", 32'h0000_300F, 32'(warningCode));
        chk("readyLed", 32'h0000_0001, 32'(readyLed));
        apb(1'b1, rws_pkg::A_WCODE, 32'h0000_0000);
        cyc(1);
        chk("warningCode", 32'h0000_300F, 32'(warningCode));
        pins(13'h0000);
        chk("warningCode", 32'h0000_0000, 32'(warningCode));
    endtask

    task automatic t_chan();
        for (int c = 0; c < 6; c++) begin
            PTR.sample(3'(c), 12'sh200, 1'b1, 12'sh000);
            #1;
            chk("filtValid", 32'h0000_0000, 32'(filtValid));
            cyc(1);
            chk("sensorEnable", (32'h0000_003F << (c + 1)) & 32'h0000_003F,
                32'(sensorEnable));
            chk("warningCode", ((32'h1 << (c + 1)) - 1) << 6,
                32'(warningCode));
        end
        for (int c = 0; c < 6; c++) begin
            PTR.sample(3'(c), 12'sh410, 1'b0, 12'sh00F);
            #1;
            chk("filtValid", 32'h0000_0001, 32'(filtValid));
            chk("filtChan", 32'(c), 32'(filtChan));
            chk("filtValue", 32'h0000_0410, 32'(filtValue));
        end
        cyc(1);
        chk("sensorEnable", 32'h0000_003F, 32'(sensorEnable));
        PTR.sample(3'h2, 12'sh411, 1'b0, 12'sh000);
        #1;
        chk("filtValid", 32'h0000_0000, 32'(filtValid));
        cyc(1);
        chk("sensorEnable", 32'h0000_003B, 32'(sensorEnable));
        chk("warningCode", 32'h0000_0020, 32'(warningCode));
        PTR.sample(3'h2, 12'sh100, 1'b0, 12'sh000);
        cyc(2);
        chk("warningCode", 32'h0000_0000, 32'(warningCode));
    endtask

    task automatic t_ref();
        PTR.sample(3'h0, 12'sh100, 1'b0, 12'sh010);
        #1;
        chk("filtValid", 32'h0000_0000, 32'(filtValid));
        cyc(1);
        chk("sensorEnable", 32'h0000_003F, 32'(sensorEnable));
        cyc(60);
        chk("sensorEnable", 32'h0000_0000, 32'(sensorEnable));
        chk("warningCode", 32'h0000_0010, 32'(warningCode));
        PTR.sample(3'h0, 12'sh100, 1'b0, 12'sh000);
        cyc(2);
        chk("sensorEnable", 32'h0000_003F, 32'(sensorEnable));
        pins(13'h0040);
        chk("sensorEnable", 32'h0000_0000, 32'(sensorEnable));
        pins(13'h0000);
        chk("sensorEnable", 32'h0000_003F, 32'(sensorEnable));
    endtask

    task automatic t_route();
        elem(9'h004, 8'h00, 8'h00, 5'b01100);
        elem(9'h003, 8'h00, 8'h00, 5'b00000);
        elem(9'h100, 8'h00, 8'h00, 5'b10000);
        elem(9'h000, 8'h04, 8'h00, 5'b00011);
        elem(9'h000, 8'h03, 8'h02, 5'b00000);
        elem(9'h000, 8'h00, 8'h80, 5'b00011);
        elem(9'h000, 8'h00, 8'h00, 5'b00000);
        apb(1'b1, rws_pkg::A_FSG1, 32'h0000_0080);
        pins(13'h0002);
        chk("signalOutputTwo", 32'h0000_0001, 32'(signalOutputTwo));
        apb(1'b1, rws_pkg::A_FSG1, 32'h0000_0000);
        cyc(2);
        chk("signalOutputTwo", 32'h0000_0000, 32'(signalOutputTwo));
        pins(13'h0000);
    endtask

    task automatic t_fault();
        apb(1'b1, rws_pkg::A_IMASK, 32'h0000_0004);
        @(posedge ref_clk);
        tripIn <= 9'h004;
        pins(13'h0080);
        chk("internalFault", 32'h0000_0000, 32'(internalFault));
        chk("powerOutputs", 32'h0000_0000, 32'(powerOutputs));
        chk("irq", 32'h0000_0001, 32'(irq));
        seen = 1'b0;
        for (int i = 0; i < 12; i++) begin
            cyc(1);
            if (readyLed === 1'b0) seen = 1'b1;
        end
        chk("readyLed flashes", 32'h0000_0001, 32'(seen));
        pins(13'h0000);
        chk("internalFault", 32'h0000_0001, 32'(internalFault));
        chk("powerOutputs", 32'h0000_0003, 32'(powerOutputs));
        apb(1'b0, rws_pkg::A_ISTAT, 32'h0000_0000);
        chk("istat", 32'h0000_0004, rd & 32'h0000_0004);
        apb(1'b1, rws_pkg::A_ISTAT, 32'h0000_0004);
        cyc(2);
        chk("irq", 32'h0000_0000, 32'(irq));
        @(posedge ref_clk);
        tripIn <= 9'h000;
    endtask

    task automatic t_din();
        apb(1'b1, rws_pkg::A_IFG, 32'h0000_0007);
        apb(1'b1, rws_pkg::A_RTRIG, 32'h0000_0001);
        @(posedge ref_clk);
        faultPins <= 13'h0100;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (recorderTrigger === 1'b1) seen = 1'b1;
        end
        chk("recorderTrigger", 32'h0000_0001, 32'(seen));
        chk("functions", 32'h0000_0007,
            32'({blockOut, unlatchOut, remoteOut}));
        pins(13'h0000);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        n_mismatch = 0;
        checked    = 0;
        resetn     = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        faultPins  = 13'h0000;
        tripIn     = 9'h000;
        pickupIn   = 8'h00;
        alarmIn    = 8'h00;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_warn();
        t_chan();
        t_ref();
        t_route();
        t_fault();
        t_din();
        test_done();
    end
endmodule
